// ===== src/legacy_link_byte_port.sv
`timescale 1ns/1ps
// Summary of operation
// - received link bits shift into an 8-bit byte, first bit lands in LSB
// - each eight new bits set the receive-byte-full flag
// - full flag with its mask enabled pulls the interrupt low
// - byte equal to either match byte sets match flag, may interrupt
// - with destuff enabled, a zero after five ones is dropped
// - a zero after six or more ones is kept
// - transmit byte goes out as frame bits (D4) only; in ESF the link bit comes from the controller or external input
// - a newly written transmit byte is sent LSB first
// - after eight bits sent, empty flag sets, may interrupt
// - with no new byte written, the old byte is sent again
// - with stuff enabled, a zero is inserted after five ones
// - with multiframe load enabled, only the first transmit byte load after idle waits for a multiframe edge
// - receive runs beside the controller; one transmit link source only
// - message fields in the frame bit slot pass through these registers
// - in ESF, controller enable low picks external input, high picks controller; in D4 the link bit is held low
module legacy_link_byte_port
   import link_byte_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   output logic INT_N,
   input wire logic ESF_MODE,
   input wire logic RX_BIT_EN,
   input wire logic RX_BIT,
   input wire logic TX_BIT_REQ,
   input wire logic MF_BOUNDARY,
   input wire logic EXTERNAL_LINK_INPUT,
   input wire logic CONTROLLER_BIT,
   output logic TX_LINK_BIT,
   output logic TX_FS_BIT,
   output logic TX_FS_FROM_REG,
   output logic [7:0] RX_BYTE_DATA,
   output logic RX_BYTE_VALID,
   input wire logic RX_BYTE_READY
);
   logic [7:0] receive_link_byte;
   logic [7:0] rx_shift_r;
   logic [2:0] rx_cnt_r;
   logic [7:0] link_match_byte_a;
   logic [7:0] link_match_byte_b;
   logic [7:0] transmit_link_byte;
   logic [7:0] tx_shift_r;
   logic [2:0] tx_cnt_r;
   logic [7:0] status_r;
   logic [7:0] mask_r;
   logic [7:0] ctrl_r;
   logic tx_pending_r;
   logic tx_out_r;
   tx_state_t tx_state_r;
   tx_state_t tx_state_nxt;
   logic wr_rx_byte_unused;
   byte_stream_if #(.WIDTH(8)) rx_in ();
   byte_stream_if #(.WIDTH(8)) rx_out ();

   // control field decode
   wire destuff_enable = ctrl_r[DESTUFF_BIT];
   wire stuff_enable = ctrl_r[STUFF_BIT];
   wire multiframe_load_enable = ctrl_r[MF_LOAD_BIT];
   wire frame_bit_source_select = ctrl_r[FS_SRC_BIT];
   wire controller_link_enable = ctrl_r[CTRL_LINK_BIT];

   // register strobes
   wire wr_match_a = WR && (ADDR == MATCH_A_ADDR);
   wire wr_match_b = WR && (ADDR == MATCH_B_ADDR);
   wire wr_tx_byte = WR && (ADDR == TX_BYTE_ADDR);
   wire wr_mask = WR && (ADDR == MASK_ADDR);
   wire wr_ctrl = WR && (ADDR == CTRL_ADDR);
   wire rd_status = RD && (ADDR == STATUS_ADDR);
   assign wr_rx_byte_unused = WR && (ADDR == RX_BYTE_ADDR);

   // receive destuff: a zero right after exactly five ones is dropped
   logic rx_run_full;
   logic [2:0] rx_ones_r;
   wire rx_is_stuffed = destuff_enable && !RX_BIT && rx_run_full;
   wire rx_accept = RX_BIT_EN && !rx_is_stuffed;
   zero_stuffer rx_runs (
      .clk(CLOCK),
      .rst(RST),
      .bit_en(RX_BIT_EN),
      .bit_in(RX_BIT),
      .run_full(rx_run_full)
   );
   // separate count tells six ones from five, so that a flag zero stays
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) rx_ones_r <= 3'h0;
      else if (RX_BIT_EN) rx_ones_r <= !RX_BIT ? 3'h0 : (rx_ones_r == BIT_LAST) ? BIT_LAST :
         rx_ones_r + 3'h1;
   end
   wire rx_exact_five = (rx_ones_r == RUN_LIMIT);
   wire rx_drop = rx_is_stuffed && rx_exact_five;
   wire rx_take = RX_BIT_EN && !rx_drop;

   // receive shifter, LSB first: new bit enters at the top
   wire [7:0] rx_shift_nxt = {RX_BIT, rx_shift_r[7:1]};
   wire rx_byte_done = rx_take && (rx_cnt_r == BIT_LAST);
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         rx_shift_r <= BYTE_RESET;
         rx_cnt_r <= 3'h0;
         receive_link_byte <= BYTE_RESET;
      end else if (rx_take) begin
         rx_shift_r <= rx_shift_nxt;
         rx_cnt_r <= rx_cnt_r + 3'h1;
         if (rx_byte_done) receive_link_byte <= rx_shift_nxt;
      end
   end
   wire rx_match = (rx_shift_nxt == link_match_byte_a) || (rx_shift_nxt == link_match_byte_b);
   wire rx_unused_accept = rx_accept;

   // completed bytes also go to the fifo for a streaming reader
   assign rx_in.valid = rx_byte_done;
   assign rx_in.data = rx_shift_nxt;
   byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rx_fifo (
      .clk(CLOCK),
      .rst(RST),
      .wr(rx_in.sink),
      .rd(rx_out.source)
   );
   assign rx_out.ready = RX_BYTE_READY;
   assign RX_BYTE_VALID = rx_out.valid;
   assign RX_BYTE_DATA = rx_out.data;

   // transmit sequencing
   wire tx_load_ok = !multiframe_load_enable || MF_BOUNDARY;
   wire tx_run_full;
   wire tx_run_full_next;
   wire tx_byte_end = (tx_state_r == TX_SEND) && TX_BIT_REQ && (tx_cnt_r == BIT_LAST) &&
      !(stuff_enable && tx_shift_r[0] && tx_run_full_next);
   wire tx_stuff_now = stuff_enable && tx_run_full;
   wire tx_cur_bit = tx_shift_r[0];
   wire tx_bit_sent = TX_BIT_REQ && (tx_state_r == TX_SEND) && !tx_stuff_now;
   assign tx_run_full_next = 1'b0;
   zero_stuffer tx_runs (
      .clk(CLOCK),
      .rst(RST),
      .bit_en(TX_BIT_REQ && (tx_state_r != TX_IDLE)),
      .bit_in(tx_stuff_now ? 1'b0 : tx_cur_bit),
      .run_full(tx_run_full)
   );
   wire tx_last_bit = tx_bit_sent && (tx_cnt_r == BIT_LAST);

   // state: idle until first write, then send forever, repeating old byte
   always_comb begin
      tx_state_nxt = tx_state_r;
      case (tx_state_r)
         TX_IDLE: if (tx_pending_r && tx_load_ok) tx_state_nxt = TX_SEND;
         TX_SEND: if (TX_BIT_REQ && tx_stuff_now) tx_state_nxt = TX_STUFF;
         TX_STUFF: tx_state_nxt = TX_SEND;
         default: tx_state_nxt = TX_IDLE;
      endcase
   end

   // shifter reload at byte end: new byte if written, else repeat; no multiframe wait here
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         tx_state_r <= TX_IDLE;
         tx_shift_r <= BYTE_RESET;
         tx_cnt_r <= 3'h0;
         tx_pending_r <= 1'b0;
         tx_out_r <= 1'b0;
      end else begin
         tx_state_r <= tx_state_nxt;
         if (TX_BIT_REQ && tx_state_r != TX_IDLE) tx_out_r <= tx_stuff_now ? 1'b0 : tx_cur_bit;
         if ((tx_state_r == TX_IDLE) && tx_pending_r && tx_load_ok) begin
            tx_shift_r <= transmit_link_byte;
            tx_cnt_r <= 3'h0;
            tx_pending_r <= wr_tx_byte;
         end else if (tx_last_bit) begin
            tx_shift_r <= transmit_link_byte;
            tx_cnt_r <= 3'h0;
            tx_pending_r <= wr_tx_byte;
         end else begin
            if (tx_bit_sent) begin
               tx_shift_r <= {tx_shift_r[0], tx_shift_r[7:1]};
               tx_cnt_r <= tx_cnt_r + 3'h1;
            end
            if (wr_tx_byte) tx_pending_r <= 1'b1;
         end
      end
   end

   // output steering: frame bits in D4, link bits in ESF, one source only
   wire link_src = controller_link_enable ? CONTROLLER_BIT : tx_out_r;
   assign TX_LINK_BIT = ESF_MODE ? (controller_link_enable ? CONTROLLER_BIT :
      EXTERNAL_LINK_INPUT) : 1'b0;
   assign TX_FS_BIT = ESF_MODE ? 1'b0 : tx_out_r;
   assign TX_FS_FROM_REG = !frame_bit_source_select;
   wire link_src_unused = link_src;

   // host registers
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         link_match_byte_a <= BYTE_RESET;
         link_match_byte_b <= BYTE_RESET;
         transmit_link_byte <= BYTE_RESET;
         mask_r <= BYTE_RESET;
         ctrl_r <= CTRL_RESET;
      end else begin
         if (wr_match_a) link_match_byte_a <= WDATA;
         if (wr_match_b) link_match_byte_b <= WDATA;
         if (wr_tx_byte) transmit_link_byte <= WDATA;
         if (wr_mask) mask_r <= WDATA;
         if (wr_ctrl) ctrl_r <= WDATA;
      end
   end

   // sticky flags: a new event in the read cycle survives the clear
   wire [7:0] status_set = {3'h0, rx_byte_done, tx_last_bit, rx_byte_done && rx_match, 2'h0};
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) status_r <= BYTE_RESET;
      else status_r <= (rd_status ? BYTE_RESET : status_r) | status_set;
   end
   assign INT_N = !(|(status_r & mask_r));

   // read data registered, one cycle after RD
   wire [7:0] rdata_nxt = (ADDR == RX_BYTE_ADDR) ? receive_link_byte :
      (ADDR == MATCH_A_ADDR) ? link_match_byte_a :
      (ADDR == MATCH_B_ADDR) ? link_match_byte_b :
      (ADDR == TX_BYTE_ADDR) ? transmit_link_byte :
      (ADDR == STATUS_ADDR) ? status_r :
      (ADDR == MASK_ADDR) ? mask_r :
      (ADDR == CTRL_ADDR) ? ctrl_r : BYTE_RESET;
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) RDATA <= BYTE_RESET;
      else if (RD) RDATA <= rdata_nxt;
   end
endmodule

// ===== shared/link_byte_pkg.sv
package link_byte_pkg;
   // register offsets on the framer's parallel port
   localparam logic [7:0] RX_BYTE_ADDR = 8'h28;
   localparam logic [7:0] MATCH_A_ADDR = 8'h29;
   localparam logic [7:0] MATCH_B_ADDR = 8'h2A;
   localparam logic [7:0] TX_BYTE_ADDR = 8'h7E;
   localparam logic [7:0] STATUS_ADDR = 8'h31;
   localparam logic [7:0] MASK_ADDR = 8'h32;
   localparam logic [7:0] CTRL_ADDR = 8'h33;
   // status and mask bit positions
   localparam int MATCH_BIT = 2;
   localparam int TX_EMPTY_BIT = 3;
   localparam int RX_FULL_BIT = 4;
   // control bit positions
   localparam int DESTUFF_BIT = 0;
   localparam int STUFF_BIT = 4;
   localparam int MF_LOAD_BIT = 5;
   localparam int FS_SRC_BIT = 2;
   localparam int CTRL_LINK_BIT = 6;
   // reset values, frame pattern and counting limits
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] D4_FS_PATTERN = 8'h1C;
   localparam logic [2:0] RUN_LIMIT = 3'h5;
   localparam logic [2:0] BIT_LAST = 3'h7;
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_SEND = 2'b01,
      TX_STUFF = 2'b10
   } tx_state_t;
endpackage

// ===== shared/byte_stream_if.sv
`timescale 1ns/1ps
interface byte_stream_if #(parameter int WIDTH = 8);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface

// ===== src/byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   byte_stream_if.sink wr,
   byte_stream_if.source rd
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wptr_r;
   logic [AW:0] rptr_r;
   logic full;
   logic empty;
   logic push;
   logic pop;
   // extra pointer bit tells full from empty
   assign empty = (wptr_r == rptr_r);
   assign full = (wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
   assign wr.ready = !full;
   assign rd.valid = !empty;
   assign rd.data = mem[rptr_r[AW-1:0]];
   assign push = wr.valid && !full;
   assign pop = rd.ready && !empty;
   // pointers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wptr_r <= '0;
         rptr_r <= '0;
      end else begin
         if (push) wptr_r <= wptr_r + 1'b1;
         if (pop) rptr_r <= rptr_r + 1'b1;
      end
   end
   // storage has no reset, only written words are read
   always_ff @(posedge clk) begin
      if (push) mem[wptr_r[AW-1:0]] <= wr.data;
   end
endmodule

// ===== src/zero_stuffer.sv
`timescale 1ns/1ps
module zero_stuffer
   import link_byte_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic bit_en,
   input wire logic bit_in,
   output logic run_full
);
   logic [2:0] ones_r;
   logic [2:0] ones_nxt;
   // run of ones, saturating at the limit; zero breaks it
   assign ones_nxt = !bit_in ? 3'h0 : (ones_r == RUN_LIMIT) ? RUN_LIMIT : ones_r + 3'h1;
   assign run_full = (ones_r == RUN_LIMIT);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) ones_r <= 3'h0;
      else if (bit_en) ones_r <= ones_nxt;
   end
endmodule

// ===== test/framer_model.sv
`timescale 1ns/1ps
// serial side of the framer: feeds receive bits and takes transmit bit slots
module framer_model (
   input wire logic clock,
   output logic rx_en,
   output logic rx_bit,
   output logic tx_req,
   input wire logic tx_bit
);
   // quiet lines until the bench asks for traffic
   initial begin
      rx_en = 1'b0;
      rx_bit = 1'b0;
      tx_req = 1'b0;
   end
   // first bit first; gap gives a slow stream as well as a prompt one
   task automatic send_bits(input logic [15:0] bits, input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         rx_en <= 1'b1;
         rx_bit <= bits[i];
         @(posedge clock);
         rx_en <= 1'b0;
         rx_bit <= ~bits[i]; // no stale bit left on the line
         repeat (gap) @(posedge clock);
      end
   endtask
   // eight slots; the bit launched at the strobe edge is read just after it settles
   task automatic take_byte(output logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         @(posedge clock);
         tx_req <= 1'b1;
         @(posedge clock);
         tx_req <= 1'b0;
         #1 b[i] = tx_bit;
      end
   endtask
endmodule

// ===== test/legacy_link_byte_port_properties.sv
`timescale 1ns/1ps
module legacy_link_byte_port_properties (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic INT_N,
   input wire logic ESF_MODE,
   input wire logic RX_BIT_EN,
   input wire logic TX_BIT_REQ,
   input wire logic MF_BOUNDARY,
   input wire logic TX_FS_BIT,
   input wire logic TX_FS_FROM_REG,
   input wire logic [7:0] RX_BYTE_DATA,
   input wire logic RX_BYTE_VALID,
   input wire logic RX_BYTE_READY
);
   logic [3:0] rx_hist_r;
   logic [3:0] tx_hist_r;
   logic [3:0] act_hist_r;
   // recent strobes; flags may lag their cause by a few cycles
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         rx_hist_r <= 4'h0;
         tx_hist_r <= 4'h0;
         act_hist_r <= 4'h0;
      end else begin
         rx_hist_r <= {rx_hist_r[2:0], RX_BIT_EN};
         tx_hist_r <= {tx_hist_r[2:0], TX_BIT_REQ | WR | MF_BOUNDARY};
         act_hist_r <= {act_hist_r[2:0], RX_BIT_EN | TX_BIT_REQ | WR};
      end
   end
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   property p_reset_idle;
      $fell(RST) |-> INT_N && RDATA == 8'h00 && !RX_BYTE_VALID;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
   property p_rdata_hold;
      !RD |=> $stable(RDATA);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
   property p_int_rise;
      $rose(INT_N) |-> $past(RD) || $past(WR);
   endproperty
   a_int_rise: assert property (p_int_rise) else $error("interrupt left without access");
   property p_int_fall;
      $fell(INT_N) |-> act_hist_r != 4'h0;
   endproperty
   a_int_fall: assert property (p_int_fall) else $error("interrupt without cause");
   property p_fs_src;
      !WR |=> $stable(TX_FS_FROM_REG);
   endproperty
   a_fs_src: assert property (p_fs_src) else $error("frame source moved alone");
   property p_fs_bit;
      $changed(TX_FS_BIT) |-> tx_hist_r != 4'h0 || $changed(ESF_MODE);
   endproperty
   a_fs_bit: assert property (p_fs_bit) else $error("frame bit moved without slot");
   property p_valid_rise;
      $rose(RX_BYTE_VALID) |-> rx_hist_r != 4'h0;
   endproperty
   a_valid_rise: assert property (p_valid_rise) else $error("byte without bits");
   property p_valid_hold;
      RX_BYTE_VALID && !RX_BYTE_READY |=> RX_BYTE_VALID && $stable(RX_BYTE_DATA);
   endproperty
   a_valid_hold: assert property (p_valid_hold) else $error("stalled byte not held");
endmodule
bind legacy_link_byte_port legacy_link_byte_port_properties legacy_link_byte_port_properties_i (
   .CLOCK(CLOCK), .RST(RST), .WR(WR), .RD(RD), .RDATA(RDATA), .INT_N(INT_N),
   .ESF_MODE(ESF_MODE), .RX_BIT_EN(RX_BIT_EN), .TX_BIT_REQ(TX_BIT_REQ),
   .MF_BOUNDARY(MF_BOUNDARY), .TX_FS_BIT(TX_FS_BIT), .TX_FS_FROM_REG(TX_FS_FROM_REG),
   .RX_BYTE_DATA(RX_BYTE_DATA), .RX_BYTE_VALID(RX_BYTE_VALID), .RX_BYTE_READY(RX_BYTE_READY));

// ===== test/legacy_link_byte_port_bench.sv
`timescale 1ns/1ps
module legacy_link_byte_port_bench
   import link_byte_pkg::*;
;
   logic clock = 0, rst = 1, wr = 0, rd = 0, esf = 0, ext_in = 0, ctl_bit = 0, rdy = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rx_data, v;
   logic int_n, rx_en, rx_bit, tx_req, link_bit, fs_bit, fs_from_reg, rx_valid;
   int fails = 0, n_compared = 0;
   logic [15:0] bits [9] = '{16'hA5, 16'h3C, 16'h11, 16'h11F, 16'h3F, 16'h1, 16'h2, 16'h3, 16'h4};
   int nb [9] = '{8, 8, 8, 9, 8, 8, 8, 8, 8};
   logic [7:0] eb [9] = '{8'hA5, 8'h3C, 8'h11, 8'h9F, 8'h3F, 8'h01, 8'h02, 8'h03, 8'h04};
   logic [7:0] st [5] = '{8'h14, 8'h14, 8'h10, 8'h10, 8'h10};
   legacy_link_byte_port legacy_link_byte_port_i (.CLOCK(clock), .RST(rst), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .INT_N(int_n), .ESF_MODE(esf),
      .RX_BIT_EN(rx_en), .RX_BIT(rx_bit), .TX_BIT_REQ(tx_req), .MF_BOUNDARY(1'b0),
      .EXTERNAL_LINK_INPUT(ext_in), .CONTROLLER_BIT(ctl_bit), .TX_LINK_BIT(link_bit),
      .TX_FS_BIT(fs_bit), .TX_FS_FROM_REG(fs_from_reg), .RX_BYTE_DATA(rx_data),
      .RX_BYTE_VALID(rx_valid), .RX_BYTE_READY(rdy));
   framer_model framer_model_i (.clock(clock), .rx_en(rx_en), .rx_bit(rx_bit),
      .tx_req(tx_req), .tx_bit(fs_bit));
   initial forever #2.5 clock = ~clock;
   // verdict in one place, also reached by a wait that runs out
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one-cycle strobes; address and data held through the taking edge
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd_reg(a, d);
      chk(d, exp);
   endtask
   task automatic wait_int();
      int i;
      for (i = 0; i < 200 && int_n !== 1'b0; i++) @(posedge clock);
      if (i == 200) begin
         fails++;
         conclude();
      end
   endtask
   initial begin
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      wr_reg(MATCH_A_ADDR, 8'hA5);
      wr_reg(MATCH_B_ADDR, 8'h3C);
      wr_reg(RX_BYTE_ADDR, 8'h77);
      rchk(MATCH_A_ADDR, 8'hA5);
      rchk(MATCH_B_ADDR, 8'h3C);
      rchk(RX_BYTE_ADDR, 8'h00); // read only place keeps reset value
      rchk(8'hF0, 8'h00);
      $display("test registers done");
      // receive: match a, match b, no match, then bytes with destuff on (one zero dropped, one kept); fifo left stalled
      wr_reg(MASK_ADDR, 8'h14);
      for (int i = 0; i < 9; i++) begin
         if (i == 3) wr_reg(CTRL_ADDR, 8'h01); // destuff kept on while extracting
         framer_model_i.send_bits(bits[i], nb[i], i % 3);
         if (i < 5) begin
            wait_int();
            rchk(STATUS_ADDR, st[i]);
            rchk(RX_BYTE_ADDR, eb[i]);
            chk({7'h0, int_n}, 8'h01);
         end
      end
      // drain: the ninth byte found the buffer full
      for (int i = 0; i < 8; i++) begin
         chk({7'h0, rx_valid}, 8'h01);
         chk(rx_data, eb[i]);
         @(posedge clock);
         rdy <= 1'b1;
         @(posedge clock);
         rdy <= 1'b0;
         #1;
      end
      chk({7'h0, rx_valid}, 8'h00);
      $display("test receive done");
      rd_reg(STATUS_ADDR, v);
      wr_reg(MASK_ADDR, 8'h08);
      chk({7'h0, fs_from_reg}, 8'h01);
      wr_reg(TX_BYTE_ADDR, D4_FS_PATTERN);
      rchk(TX_BYTE_ADDR, 8'h1C);
      framer_model_i.take_byte(v);
      chk(v, 8'h1C);
      wait_int();
      rchk(STATUS_ADDR, 8'h08);
      framer_model_i.take_byte(v);
      chk(v, 8'h1C);
      wr_reg(TX_BYTE_ADDR, 8'h6B); // next byte inside the window
      // the shifter already reloaded the old byte, so the new one follows it
      framer_model_i.take_byte(v);
      chk(v, 8'h1C);
      framer_model_i.take_byte(v);
      chk(v, 8'h6B);
      $display("test transmit done");
      // link source: controller, then external input
      @(posedge clock);
      esf <= 1'b1;
      wr_reg(CTRL_ADDR, 8'h45);
      for (int i = 0; i < 4; i++) begin
         if (i == 2) wr_reg(CTRL_ADDR, 8'h01);
         @(posedge clock);
         ctl_bit <= i[0];
         ext_in <= ~i[0];
         @(posedge clock);
         #1 chk({7'h0, link_bit}, {7'h0, i < 2 ? i[0] : ~i[0]});
         chk({7'h0, fs_from_reg}, {7'h0, i > 1});
      end
      $display("test link source done");
      conclude();
   end
endmodule
